// ---- pkg/timer_params.svh ----
// named offsets, field positions, reset values and counts of the timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// register offsets on the plain register port
`define TMR_ADDR_CTL 3'h0
`define TMR_ADDR_CNT 3'h1
`define TMR_ADDR_CMP 3'h2
`define TMR_ADDR_STATUS 3'h3

// timer_control field positions
`define CTL_FORCE_BIT 7
`define CTL_WGM0_BIT 6
`define CTL_COM_HI 5
`define CTL_COM_LO 4
`define CTL_WGM1_BIT 3
`define CTL_CS_HI 2
`define CTL_CS_LO 0

// async_clock_status field positions
`define ST_ASYNC_BIT 3
`define ST_CNT_UB_BIT 2
`define ST_CMP_UB_BIT 1
`define ST_CTL_UB_BIT 0

// reset values and counter limits
`define REG_RESET 8'h00
`define CNT_TOP_MAX 8'hff
`define CNT_BOTTOM 8'h00
`define CNT_STEP 8'h01
`define FORCE_MASK 8'h7f

// clock select codes and prescaler tap widths (log2 of the divisor)
`define CS_STOP 3'h0
`define CS_DIRECT 3'h1
`define CS_DIV8 3'h2
`define CS_DIV32 3'h3
`define CS_DIV64 3'h4
`define CS_DIV128 3'h5
`define CS_DIV256 3'h6
`define CS_DIV1024 3'h7
`define TAP_DIV8 3
`define TAP_DIV32 5
`define TAP_DIV64 6
`define TAP_DIV128 7
`define TAP_DIV256 8
`define TAP_DIV1024 10

`endif

// ---- pkg/timer_pkg.sv ----
// types shared by the timer modules
`default_nettype none
package timer_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] addr_t;
  typedef logic [2:0] clk_sel_t;
  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'b00,
    WAVE_PHASE = 2'b01,
    WAVE_CTC = 2'b10,
    WAVE_FAST = 2'b11
  } wave_mode_t;
  typedef enum logic [1:0] {
    STAGE_IDLE = 2'b00,
    STAGE_EDGE1 = 2'b01,
    STAGE_EDGE2 = 2'b10
  } stage_t;
endpackage : timer_pkg
`default_nettype wire

// ---- pkg/tick_if.sv ----
// timer source tick and clock select passed to the prescaler
`timescale 1ns/10ps
`default_nettype none
interface tick_if;
  logic src_tick;
  timer_pkg::clk_sel_t clk_sel;
  logic timer_tick;
  modport source (output src_tick, output clk_sel, input timer_tick);
  modport presc (input src_tick, input clk_sel, output timer_tick);
endinterface : tick_if
`default_nettype wire

// ---- src/tick_prescaler.sv ----
// prescaler that turns source ticks into counter ticks
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"
module tick_prescaler #(
  parameter int PRE_W = `TAP_DIV1024
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  tick_if.presc port
);
  import timer_pkg::*;
  logic [PRE_W-1:0] pre_q;

  // free running so switching taps never restarts the division
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_q <= '0;
    end else if (port.src_tick) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // tap select: a tap fires when all bits below it are ones
  always_comb begin
    case (port.clk_sel)
      `CS_STOP: port.timer_tick = 1'b0;
      `CS_DIRECT: port.timer_tick = port.src_tick;
      `CS_DIV8: port.timer_tick = port.src_tick & (&pre_q[`TAP_DIV8-1:0]);
      `CS_DIV32: port.timer_tick = port.src_tick & (&pre_q[`TAP_DIV32-1:0]);
      `CS_DIV64: port.timer_tick = port.src_tick & (&pre_q[`TAP_DIV64-1:0]);
      `CS_DIV128: port.timer_tick = port.src_tick & (&pre_q[`TAP_DIV128-1:0]);
      `CS_DIV256: port.timer_tick = port.src_tick & (&pre_q[`TAP_DIV256-1:0]);
      default: port.timer_tick = port.src_tick & (&pre_q);
    endcase
  end
endmodule : tick_prescaler
`default_nettype wire

// ---- src/write_stage.sv ----
// temporary write register with busy flag for one timer register
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"
module write_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_in,
  input wire logic async_in,
  input wire logic xtal_rise_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] temp_out,
  output logic load_out,
  output logic busy_out
);
  import timer_pkg::*;
  stage_t state_q;

  // temporary register always takes the written value
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      temp_out <= '0;
    end else if (wr_in) begin
      temp_out <= data_in;
    end
  end

  // wait for two crystal rises; a new write restarts the wait
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= STAGE_IDLE;
    end else if (wr_in) begin
      state_q <= async_in ? STAGE_EDGE1 : STAGE_IDLE;
    end else begin
      case (state_q)
        STAGE_EDGE1: if (xtal_rise_in) state_q <= STAGE_EDGE2;
        STAGE_EDGE2: if (xtal_rise_in) state_q <= STAGE_IDLE;
        default: state_q <= STAGE_IDLE;
      endcase
    end
  end

  // load pulse: next cycle when synchronous, on second rise otherwise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      load_out <= 1'b0;
    end else begin
      load_out <= (wr_in && !async_in) ||
        (!wr_in && state_q == STAGE_EDGE2 && xtal_rise_in);
    end
  end

  // busy: a write wins over a clear in the same cycle;
  // a synchronous write drops a flag left from crystal mode
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b0;
    end else if (wr_in) begin
      busy_out <= async_in;
    end else if (!wr_in && state_q == STAGE_EDGE2 && xtal_rise_in) begin
      busy_out <= 1'b0;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_BUSY_SET: assert property (wr_in && async_in |=> busy_out)
    else $error("busy flag not set by asynchronous write");
  AST_BUSY_CLEAR: assert property ($fell(busy_out) |-> load_out)
    else $error("busy flag cleared without a load");
endmodule : write_stage
`default_nettype wire

// ---- src/async_timer_compare.sv ----
// eight-bit timer with one compare output and crystal-clocked mode
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"
module async_timer_compare (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire timer_pkg::addr_t addr_in,
  input wire timer_pkg::byte_t wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output timer_pkg::byte_t rd_data_out,
  input wire logic crystal_osc_input_in,
  output logic compare_output_pin_out,
  output logic pin_override_out,
  output logic compare_match_out
);
  import timer_pkg::*;

  logic xtal_s1_q, xtal_s2_q, xtal_s3_q;
  logic xtal_rise;
  logic async_sel_q;
  logic wr_ctl, wr_cnt, wr_cmp, wr_status;
  byte_t ctl_temp, cmp_temp, cnt_temp;
  logic ctl_load, cmp_load, cnt_load;
  logic ctl_busy, cmp_busy, cnt_busy;
  byte_t ctl_q, cmp_buf_q, cmp_act_q, cnt_q;
  logic dir_up_q, block_q, oc_q, force_pulse;
  wave_mode_t mode;
  logic [1:0] com;
  logic [1:0] force_com;
  logic pwm_mode, timer_tick, match_hit, top_hit, special_top;
  byte_t status;

  // crystal pin passes two flops before the edge detector reads it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_s3_q <= 1'b0;
    end else begin
      xtal_s1_q <= crystal_osc_input_in;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
    end
  end
  assign xtal_rise = xtal_s2_q & ~xtal_s3_q;

  // write decode; the host port never stalls
  assign wr_ctl = wr_in && addr_in == `TMR_ADDR_CTL;
  assign wr_cnt = wr_in && addr_in == `TMR_ADDR_CNT;
  assign wr_cmp = wr_in && addr_in == `TMR_ADDR_CMP;
  assign wr_status = wr_in && addr_in == `TMR_ADDR_STATUS;

  // clock source select; busy bits in the same register are read only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      async_sel_q <= 1'b0;
    end else if (wr_status) begin
      async_sel_q <= wr_data_in[`ST_ASYNC_BIT];
    end
  end

  // one staging register each for control, compare and count, so writes never collide
  write_stage #(.WIDTH(8)) u_ctl_stage (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_ctl),
    .async_in(async_sel_q),
    .xtal_rise_in(xtal_rise),
    .data_in(wr_data_in),
    .temp_out(ctl_temp),
    .load_out(ctl_load),
    .busy_out(ctl_busy)
  );
  write_stage #(.WIDTH(8)) u_cmp_stage (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_cmp),
    .async_in(async_sel_q),
    .xtal_rise_in(xtal_rise),
    .data_in(wr_data_in),
    .temp_out(cmp_temp),
    .load_out(cmp_load),
    .busy_out(cmp_busy)
  );
  write_stage #(.WIDTH(8)) u_cnt_stage (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_cnt),
    .async_in(async_sel_q),
    .xtal_rise_in(xtal_rise),
    .data_in(wr_data_in),
    .temp_out(cnt_temp),
    .load_out(cnt_load),
    .busy_out(cnt_busy)
  );

  // active control register; the force bit is a strobe and is not kept
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctl_q <= `REG_RESET;
    end else if (ctl_load) begin
      ctl_q <= ctl_temp & `FORCE_MASK;
    end
  end

  // field decode of the active control register
  assign mode = wave_mode_t'({ctl_q[`CTL_WGM1_BIT], ctl_q[`CTL_WGM0_BIT]});
  assign com = ctl_q[`CTL_COM_HI:`CTL_COM_LO];
  assign force_com = ctl_temp[`CTL_COM_HI:`CTL_COM_LO];
  assign pwm_mode = mode == WAVE_PHASE || mode == WAVE_FAST;
  assign force_pulse = ctl_load && ctl_temp[`CTL_FORCE_BIT] &&
    !ctl_temp[`CTL_WGM0_BIT];

  // timer source: undivided clock, or synchronised crystal rises
  tick_if u_tick ();
  assign u_tick.src_tick = async_sel_q ? xtal_rise : 1'b1;
  assign u_tick.clk_sel = ctl_q[`CTL_CS_HI:`CTL_CS_LO];
  assign timer_tick = u_tick.timer_tick;
  tick_prescaler #(.PRE_W(`TAP_DIV1024)) u_presc (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .port(u_tick.presc)
  );

  // compare buffering: immediate in non-PWM, at top in PWM to avoid glitches
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp_buf_q <= `REG_RESET;
    end else if (cmp_load) begin
      cmp_buf_q <= cmp_temp;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp_act_q <= `REG_RESET;
    end else if (!pwm_mode || top_hit) begin
      cmp_act_q <= cmp_buf_q;
    end
  end

  // counter: a software load wins over counting
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= `REG_RESET;
    end else if (cnt_load) begin
      cnt_q <= cnt_temp;
    end else if (timer_tick) begin
      case (mode)
        WAVE_CTC: cnt_q <= (cnt_q == cmp_act_q) ? `CNT_BOTTOM
                                                : cnt_q + `CNT_STEP;
        WAVE_PHASE: begin
          if ((dir_up_q && cnt_q != `CNT_TOP_MAX) || cnt_q == `CNT_BOTTOM) begin
            cnt_q <= cnt_q + `CNT_STEP;
          end else begin
            cnt_q <= cnt_q - `CNT_STEP;
          end
        end
        default: cnt_q <= cnt_q + `CNT_STEP;
      endcase
    end
  end

  // count direction for the dual slope mode
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir_up_q <= 1'b1;
    end else if (mode != WAVE_PHASE) begin
      dir_up_q <= 1'b1;
    end else if (timer_tick && !cnt_load) begin
      if (cnt_q == `CNT_TOP_MAX) begin
        dir_up_q <= 1'b0;
      end else if (cnt_q == `CNT_BOTTOM) begin
        dir_up_q <= 1'b1;
      end
    end
  end

  // match blocking after a counter write, held until the next tick
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      block_q <= 1'b0;
    end else if (cnt_load) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  // match and top events, seen only on counter ticks
  assign match_hit = timer_tick && !block_q && !cnt_load &&
    cnt_q == cmp_act_q;
  assign top_hit = pwm_mode && timer_tick && !cnt_load &&
    cnt_q == `CNT_TOP_MAX;
  assign special_top = pwm_mode && com[1] && cmp_act_q == `CNT_TOP_MAX;

  // waveform register; a force strobe acts like a match without a flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      oc_q <= 1'b0;
    end else if (force_pulse) begin
      case (force_com)
        2'h1: oc_q <= ~oc_q;
        2'h2: oc_q <= 1'b0;
        2'h3: oc_q <= 1'b1;
        default: oc_q <= oc_q;
      endcase
    end else begin
      case (mode)
        WAVE_FAST: begin
          if (top_hit && com[1]) begin
            oc_q <= ~com[0];
          end else if (match_hit && com[1] && !special_top) begin
            oc_q <= com[0];
          end
        end
        WAVE_PHASE: begin
          if (top_hit && special_top) begin
            oc_q <= ~com[0];
          end else if (match_hit && com[1]) begin
            oc_q <= dir_up_q ? com[0] : ~com[0];
          end
        end
        default: begin
          if (match_hit) begin
            case (com)
              2'h1: oc_q <= ~oc_q;
              2'h2: oc_q <= 1'b0;
              2'h3: oc_q <= 1'b1;
              default: oc_q <= oc_q;
            endcase
          end
        end
      endcase
    end
  end
  assign compare_output_pin_out = oc_q;
  assign pin_override_out = |com;

  // match pulse for the interrupt flag logic outside the block
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      compare_match_out <= 1'b0;
    end else begin
      compare_match_out <= match_hit;
    end
  end

  // status word assembled from its fields
  always_comb begin
    status = `REG_RESET;
    status[`ST_ASYNC_BIT] = async_sel_q;
    status[`ST_CNT_UB_BIT] = cnt_busy;
    status[`ST_CMP_UB_BIT] = cmp_busy;
    status[`ST_CTL_UB_BIT] = ctl_busy;
  end

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= `REG_RESET;
    end else if (rd_in) begin
      case (addr_in)
        `TMR_ADDR_CTL: rd_data_out <= ctl_temp & `FORCE_MASK;
        `TMR_ADDR_CNT: rd_data_out <= cnt_q;
        `TMR_ADDR_CMP: rd_data_out <= cmp_temp;
        `TMR_ADDR_STATUS: rd_data_out <= status;
        default: rd_data_out <= `REG_RESET;
      endcase
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_PIN_OVERRIDE: assert property (
    ctl_load |=> pin_override_out == (|$past(force_com)))
    else $error("pin override does not follow compare mode");
  AST_STOPPED: assert property (
    ctl_q[`CTL_CS_HI:`CTL_CS_LO] == `CS_STOP && !cnt_load |=> $stable(cnt_q))
    else $error("counter moved with clock stopped");
  AST_DIRECT_COUNT: assert property (
    ctl_q[`CTL_CS_HI:`CTL_CS_LO] == `CS_DIRECT && !async_sel_q &&
    mode == WAVE_NORMAL && !cnt_load && !ctl_load
    |=> cnt_q == $past(cnt_q) + `CNT_STEP)
    else $error("counter did not advance on undivided clock");
  AST_CNT_READ: assert property (
    rd_in && addr_in == `TMR_ADDR_CNT |=> rd_data_out == $past(cnt_q))
    else $error("counter read does not return live count");
  AST_CMP_READ: assert property (
    rd_in && addr_in == `TMR_ADDR_CMP |=> rd_data_out == $past(cmp_temp))
    else $error("compare read does not return temporary");
  AST_BLOCK_MATCH: assert property (
    cnt_load ##1 (!timer_tick && !cnt_load) [*2] |-> block_q)
    else $error("match block lost before next tick");
  AST_TOGGLE: assert property (
    match_hit && !force_pulse && mode == WAVE_NORMAL && com == 2'h1
    |=> oc_q != $past(oc_q))
    else $error("compare output did not toggle on match");
  AST_FORCE_SET: assert property (
    force_pulse && force_com == 2'h3 |=> oc_q)
    else $error("forced compare did not set output");
  AST_FAST_TOP: assert property (
    top_hit && !force_pulse && mode == WAVE_FAST && com == 2'h2 |=> oc_q)
    else $error("fast mode output not set at top");
  // match and top actions per mode; a force strobe in the same cycle has priority
  AST_FAST_CLEAR: assert property (
    match_hit && !top_hit && !force_pulse && mode == WAVE_FAST &&
    com == 2'h2 |=> !oc_q)
    else $error("fast mode output not cleared on match");
  AST_PHASE_UP: assert property (
    match_hit && !top_hit && !force_pulse && mode == WAVE_PHASE &&
    com == 2'h2 && dir_up_q |=> !oc_q)
    else $error("phase mode output not cleared on up match");
  AST_PHASE_DOWN: assert property (
    match_hit && !top_hit && !force_pulse && mode == WAVE_PHASE &&
    com == 2'h2 && !dir_up_q |=> oc_q)
    else $error("phase mode output not set on down match");
  AST_PHASE_TOP: assert property (
    top_hit && !force_pulse && mode == WAVE_PHASE && special_top &&
    com == 2'h3 |=> !oc_q)
    else $error("phase mode top action missing");
  AST_CTC_WRAP: assert property (
    timer_tick && !cnt_load && mode == WAVE_CTC && cnt_q == cmp_act_q
    |=> cnt_q == `CNT_BOTTOM)
    else $error("clear on compare did not wrap counter");
endmodule : async_timer_compare
`default_nettype wire

// ---- testbench/async_timer_compare_test.sv ----
// self-checking bench of the eight-bit timer with compare output
`timescale 1ns/10ps
`default_nettype none
`include "timer_params.svh"
module async_timer_compare_test;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic xtal = 1'b0;
  logic xtal_on = 1'b0;
  addr_t addr = 3'h0;
  byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  byte_t rdata;
  logic pin;
  logic ovr;
  logic match;
  int err_total = 0;
  int n_checks = 0;
  int hi;
  int pulses;
  int k;
  int cnt_model = 0;
  logic [31:0] seed = 32'h51a3;
  byte_t v;
  byte_t p;
  logic p1;
  // model tables: divisors, then pwm and ctc cases (compare, control, window, result)
  int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
  byte_t cmp_t [5] = '{8'h80, 8'hff, 8'h80, 8'h3f, 8'hff};
  byte_t ctl_t [5] = '{8'h69, 8'h69, 8'h61, 8'h19, 8'h71};
  int win_t [5] = '{256, 256, 510, 256, 510};
  int hi_t [5] = '{129, 256, 256, 128, 0};
  int pul_t [5] = '{1, -1, 2, 4, -1};
  addr_t as_a [3] = '{`TMR_ADDR_CMP, `TMR_ADDR_CTL, `TMR_ADDR_CNT};
  int as_b [3] = '{1, 0, 2};

  async_timer_compare DUT (
    .clk_in(clk),
    .rstn_in(rstn),
    .addr_in(addr),
    .wr_data_in(wdata),
    .wr_in(wr),
    .rd_in(rd),
    .rd_data_out(rdata),
    .crystal_osc_input_in(xtal),
    .compare_output_pin_out(pin),
    .pin_override_out(ovr),
    .compare_match_out(match)
  );

  // 250 MHz clock
  always #2 clk = ~clk;
  // crystal free-runs once chosen; 42 ns period keeps it unrelated to clk
  // non-blocking, so an edge landing on a clock edge is seen after it
  always #21 if (xtal_on) xtal <= ~xtal;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input addr_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // read data appear in the cycle after the strobe and hold until the next read
  task automatic reg_rd(input addr_t a, output byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // read strobe right behind the write, before the load can land
  task automatic wr_rd(input addr_t a, input byte_t d, output byte_t q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask : wr_rd

  // counts pin-high cycles and match pulses over a window
  task automatic measure(input int n);
    hi = 0;
    pulses = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      hi += int'(pin === 1'b1);
      pulses += int'(match === 1'b1);
    end
  endtask : measure

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // watchdog: 30k cycles, about three times the expected run
  initial begin
    #120000;
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    check("outputs after reset", {pin, ovr, match}, 16'h0);
    // reset values, unmapped offset 5 reads zero
    for (int a = 0; a < 6; a++) begin
      if (a != 4) begin
        reg_rd(addr_t'(a), v);
        check("reset value", v, 16'h0);
      end
    end
    // random compare readback; counter stopped, live count returned
    repeat (4) begin
      seed = lfsr(seed);
      reg_wr(`TMR_ADDR_CMP, seed[7:0]);
      reg_rd(`TMR_ADDR_CMP, v);
      check("compare", v, seed[7:0]);
      wr_rd(`TMR_ADDR_CNT, seed[15:8], v);
      check("live count", v, 16'(cnt_model));
      cnt_model = seed[15:8];
      repeat (20) @(posedge clk);
      reg_rd(`TMR_ADDR_CNT, v);
      check("stopped count", v, 16'(cnt_model));
    end
    // force strobe with set mode; force bit reads zero
    reg_wr(`TMR_ADDR_CTL, 8'hb0);
    reg_rd(`TMR_ADDR_CTL, v);
    check("control", v, 16'h30);
    check("override", ovr, 16'h1);
    check("forced pin", pin, 16'h1);
    reg_wr(`TMR_ADDR_CTL, 8'h00);
    repeat (4) @(posedge clk);
    check("override off", ovr, 16'h0);
    // each select: free-running prescaler gives two ticks per 2*div cycles
    for (int c = 1; c < 8; c++) begin
      reg_wr(`TMR_ADDR_CTL, byte_t'(c));
      reg_rd(`TMR_ADDR_CNT, p);
      repeat (2 * divs[c-1] - 2) @(posedge clk);
      reg_rd(`TMR_ADDR_CNT, v);
      check("ticks", v, 16'(byte_t'(p + 8'h02)));
    end
    // normal mode: one match per wrap, then toggle, clear or set
    reg_wr(`TMR_ADDR_CMP, 8'h40);
    for (int m = 1; m < 4; m++) begin
      reg_wr(`TMR_ADDR_CTL, byte_t'((m << 4) | 1));
      repeat (8) @(posedge clk);
      #1 p1 = pin;
      measure(256);
      check("match count", 16'(pulses), 16'h1);
      check("pin", pin, (m == 1) ? !p1 : (m == 3));
    end
    // counter loaded with the compare value: the next tick gives no match
    reg_wr(`TMR_ADDR_CNT, 8'h80);
    repeat (5) @(posedge clk);
    reg_wr(`TMR_ADDR_CNT, 8'h40);
    measure(200);
    check("blocked match", 16'(pulses), 16'h0);
    // pwm duty over one full period, ctc toggling over four counter periods
    for (int i = 0; i < 5; i++) begin
      reg_wr(`TMR_ADDR_CTL, 8'h01);
      reg_wr(`TMR_ADDR_CMP, cmp_t[i]);
      reg_wr(`TMR_ADDR_CTL, ctl_t[i]);
      repeat (600) @(posedge clk);
      measure(win_t[i]);
      check("high cycles", 16'(hi), 16'(hi_t[i]));
      if (pul_t[i] >= 0) begin
        check("pulses", 16'(pulses), 16'(pul_t[i]));
      end
    end
    // crystal clocking: busy bits read only, set by writes, cleared later
    reg_wr(`TMR_ADDR_CTL, 8'h00);
    reg_wr(`TMR_ADDR_STATUS, 8'hff);
    reg_rd(`TMR_ADDR_STATUS, v);
    check("status", v, 16'h08);
    xtal_on = 1'b1;
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      p = (r == 1) ? 8'h30 : seed[7:0];
      reg_wr(as_a[r], p);
      reg_rd(`TMR_ADDR_STATUS, v);
      check("busy set", v, 16'(8'h08 | (8'h01 << as_b[r])));
      k = 0;
      do begin
        reg_rd(`TMR_ADDR_STATUS, v);
        k++;
      end while (v[as_b[r]] !== 1'b0 && k < 100);
      check("busy clear", v, 16'h08);
      reg_rd(as_a[r], v);
      check("async value", v, p);
    end
    check("override async", ovr, 16'h1);
    summarize();
  end
endmodule : async_timer_compare_test
`default_nettype wire
